// file: hdl/simt_regs.sv
// Integration test registers of the static memory controller
// Functional notes
// RULE1: Test enable routes outputs from drive register, other outputs tied off.
// RULE2: In test mode input pins may toggle without upsetting functional logic.
// RULE3: Software writes zero to config bits 31..1; those read undefined.
// RULE4: Read-only input view register at 0x1E04 shows selected inputs.
// RULE5: Input view reads are refused while the controller is in Reset.
// RULE6: Input view bit 5 memory clock tie, bit 4 AHB clock tie.
// RULE7: Input view bit 3 EBI backoff, bit 2 EBI grant.
// RULE8: Input view bit 1 bus share tie, bit 0 low-power request.
// RULE9: Write-only drive register at 0x1E08, unreadable in Reset state.
// RULE10: Drive bit 2 appears on shared bus request output in test mode.
// RULE11: Drive bit 1 appears on low-power acknowledge output in test mode.
// RULE12: Drive bit 0 appears on clock active output in test mode.
// RULE13: Software writes zero to drive register bits 31..3.
// RULE14: Config register at 0x1E00, read/write, resets to zero.
// RULE15: Config reads and writes are blocked in the Reset state.
// RULE16: Without test enable, functional logic drives outputs and sees inputs.
`timescale 1ns/1ps
module simt_regs #(
   parameter int OTHER_W = 8
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic ctrl_reset_state_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [simt_pkg::ADDR_W-1:0] paddr_in,
   input wire logic [simt_pkg::DATA_W-1:0] pwdata_in,
   output logic [simt_pkg::DATA_W-1:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic mem_clock_sync_tie_in,
   input wire logic ahb_clock_sync_tie_in,
   input wire logic external_bus_share_tie_in,
   input wire logic ebi_backoff_in,
   input wire logic ebi_grant_in,
   input wire logic lowpower_request_in,
   input wire logic func_shared_bus_request_in,
   input wire logic func_lowpower_ack_in,
   input wire logic func_clock_active_in,
   input wire logic [OTHER_W-1:0] func_other_in,
   output logic shared_bus_request_out,
   output logic lowpower_ack_out,
   output logic clock_active_out,
   output logic [OTHER_W-1:0] other_out,
   output logic core_ebi_backoff_out,
   output logic core_ebi_grant_out,
   output logic core_lowpower_request_out,
   output logic test_mode_out
);
   import simt_pkg::*;

   // -------------------------------------------------------------------
   // Decode
   // -------------------------------------------------------------------
   logic test_en_q;
   logic [DRIVE_W-1:0] drive_q;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic hit_cfg;
   logic hit_in;
   logic hit_out;
   logic refused;
   logic setup;
   logic access;
   logic wr_ok;

   assign hit_cfg = (paddr_in == OFF_TEST_CONFIG);
   assign hit_in = (paddr_in == OFF_INPUT_VIEW);
   assign hit_out = (paddr_in == OFF_OUTPUT_DRIVE);
   assign setup = psel_in && !penable_in;
   assign access = psel_in && penable_in;

   // Unmapped address, a register locked by the Reset state, or a write to the read-only input view outside the Reset state
   always_comb
   begin
      refused = 1'b0;
      if (!(hit_cfg || hit_in || hit_out))
      begin
         refused = 1'b1;
      end
      else if (ctrl_reset_state_in)
      begin
         if (hit_cfg)
         begin
            refused = 1'b1; // [RULE15]
         end
         else if (hit_in && !pwrite_in)
         begin
            refused = 1'b1; // [RULE5]
         end
         else if (hit_out && !pwrite_in)
         begin
            refused = 1'b1; // [RULE9]
         end
      end
      else if (hit_in && pwrite_in)
      begin
         refused = 1'b1; // [RULE4]
      end
   end

   assign wr_ok = access && pwrite_in && !refused;

   // -------------------------------------------------------------------
   // Configuration register
   // -------------------------------------------------------------------
   // Only the enable bit is stored; upper bits are dropped
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         test_en_q <= CONFIG_RESET; // [RULE14]
      end
      else if (wr_ok && hit_cfg)
      begin
         test_en_q <= pwdata_in[CFG_TEST_MUX_ENABLE]; // [RULE14] [RULE3]
      end
   end

   // -------------------------------------------------------------------
   // Output drive register
   // -------------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         drive_q <= DRIVE_RESET;
      end
      else if (wr_ok && hit_out)
      begin
         drive_q <= pwdata_in[DRIVE_W-1:0]; // [RULE9] [RULE13]
      end
   end

   // -------------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------------
   // Captured in the setup phase so it stands through the access phase
   always_comb
   begin
      rdata_d = READ_ZERO;
      if (!refused && !pwrite_in)
      begin
         if (hit_cfg)
         begin
            rdata_d[CFG_TEST_MUX_ENABLE] = test_en_q; // [RULE3]
         end
         else if (hit_in)
         begin
            rdata_d[IN_MEM_CLOCK_SYNC] = mem_clock_sync_tie_in; // [RULE6]
            rdata_d[IN_AHB_CLOCK_SYNC] = ahb_clock_sync_tie_in;
            rdata_d[IN_EBI_BACKOFF] = ebi_backoff_in; // [RULE7]
            rdata_d[IN_EBI_GRANT] = ebi_grant_in;
            rdata_d[IN_BUS_SHARE] = external_bus_share_tie_in; // [RULE8]
            rdata_d[IN_LOWPOWER_REQ] = lowpower_request_in;
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         rdata_q <= READ_ZERO;
      end
      else if (setup)
      begin
         rdata_q <= rdata_d; // [RULE4]
      end
   end

   assign prdata_out = rdata_q;
   assign pready_out = 1'b1;
   assign pslverr_out = access && refused;
   assign test_mode_out = test_en_q;

   // -------------------------------------------------------------------
   // Pin steering
   // -------------------------------------------------------------------
   simt_mux #(
      .OTHER_W(OTHER_W)
   ) u_mux (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .test_en_in(test_en_q), // [RULE1]
      .drive_in(drive_q),
      .func_shared_bus_request_in(func_shared_bus_request_in),
      .func_lowpower_ack_in(func_lowpower_ack_in),
      .func_clock_active_in(func_clock_active_in),
      .func_other_in(func_other_in),
      .ebi_backoff_in(ebi_backoff_in),
      .ebi_grant_in(ebi_grant_in),
      .lowpower_request_in(lowpower_request_in),
      .shared_bus_request_out(shared_bus_request_out),
      .lowpower_ack_out(lowpower_ack_out),
      .clock_active_out(clock_active_out),
      .other_out(other_out),
      .core_ebi_backoff_out(core_ebi_backoff_out),
      .core_ebi_grant_out(core_ebi_grant_out),
      .core_lowpower_request_out(core_lowpower_request_out)
   );

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   sequence s_view_setup;
      setup && !pwrite_in && hit_in && !ctrl_reset_state_in;
   endsequence

   sequence s_cfg_write_locked;
      access && pwrite_in && hit_cfg && ctrl_reset_state_in;
   endsequence

   property p_view_low;
      s_view_setup |=> prdata_out[IN_VIEW_W-1:0] == $past({mem_clock_sync_tie_in,
         ahb_clock_sync_tie_in, ebi_backoff_in, ebi_grant_in,
         external_bus_share_tie_in, lowpower_request_in});
   endproperty
   a_view_low: assert property (p_view_low) // [RULE6]
      else $error("input view bits differ from pins");

   property p_view_high;
      s_view_setup |=> prdata_out[DATA_W-1:IN_VIEW_W] == '0;
   endproperty
   a_view_high: assert property (p_view_high) // [RULE4]
      else $error("input view upper bits not zero");

   property p_view_locked;
      access && !pwrite_in && hit_in && ctrl_reset_state_in |-> pslverr_out;
   endproperty
   a_view_locked: assert property (p_view_locked) // [RULE5]
      else $error("input view read allowed in Reset state");

   property p_cfg_locked;
      s_cfg_write_locked |=> $stable(test_en_q) && $stable(test_mode_out);
   endproperty
   a_cfg_locked: assert property (p_cfg_locked) // [RULE15]
      else $error("config written in Reset state");

   property p_cfg_write;
      access && pwrite_in && hit_cfg && !ctrl_reset_state_in
         |=> test_mode_out == $past(pwdata_in[CFG_TEST_MUX_ENABLE]);
   endproperty
   a_cfg_write: assert property (p_cfg_write) // [RULE14]
      else $error("config write not stored");

   property p_drive_write;
      access && pwrite_in && hit_out |=> drive_q == $past(pwdata_in[DRIVE_W-1:0]);
   endproperty
   a_drive_write: assert property (p_drive_write) // [RULE9]
      else $error("drive register write not stored");

   property p_drive_to_pin;
      test_mode_out ##1 test_mode_out |-> clock_active_out == $past(drive_q[DRV_CLOCK_ACTIVE])
         && lowpower_ack_out == $past(drive_q[DRV_LOWPOWER_ACK]);
   endproperty
   a_drive_to_pin: assert property (p_drive_to_pin) // [RULE12]
      else $error("drive bits not on pins in test mode");

   property p_ack_pin;
      test_mode_out |=> lowpower_ack_out == $past(drive_q[DRV_LOWPOWER_ACK]);
   endproperty
   a_ack_pin: assert property (p_ack_pin) // [RULE11]
      else $error("low-power acknowledge not from drive register");

   property p_mode_off;
      !test_mode_out |=> clock_active_out == $past(func_clock_active_in);
   endproperty
   a_mode_off: assert property (p_mode_off) // [RULE16]
      else $error("clock active not functional outside test mode");

endmodule

// file: inc/simt_pkg.sv
// Constants for the static memory integration test registers
package simt_pkg;

   // -------------------------------------------------------------------
   // Bus geometry
   // -------------------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int ADDR_W = 13;

   // -------------------------------------------------------------------
   // Register offsets
   // -------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_TEST_CONFIG = 13'h1E00;
   localparam logic [ADDR_W-1:0] OFF_INPUT_VIEW = 13'h1E04;
   localparam logic [ADDR_W-1:0] OFF_OUTPUT_DRIVE = 13'h1E08;

   // -------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------
   localparam int CFG_TEST_MUX_ENABLE = 0;
   localparam int IN_MEM_CLOCK_SYNC = 5;
   localparam int IN_AHB_CLOCK_SYNC = 4;
   localparam int IN_EBI_BACKOFF = 3;
   localparam int IN_EBI_GRANT = 2;
   localparam int IN_BUS_SHARE = 1;
   localparam int IN_LOWPOWER_REQ = 0;
   localparam int IN_VIEW_W = 6;
   localparam int DRV_SHARED_BUS_REQ = 2;
   localparam int DRV_LOWPOWER_ACK = 1;
   localparam int DRV_CLOCK_ACTIVE = 0;
   localparam int DRIVE_W = 3;

   // -------------------------------------------------------------------
   // Reset and tie-off values
   // -------------------------------------------------------------------
   localparam logic CONFIG_RESET = 1'h0;
   localparam logic [DRIVE_W-1:0] DRIVE_RESET = 3'h0;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
   localparam logic TIE_OUTPUT = 1'h0;
   localparam logic TIE_CORE_BACKOFF = 1'h0;
   localparam logic TIE_CORE_GRANT = 1'h0;
   localparam logic TIE_CORE_LOWPOWER_REQ = 1'h0;

endpackage

// file: hdl/simt_mux.sv
// Output and input steering between functional logic, test register and pins
`timescale 1ns/1ps
module simt_mux #(
   parameter int OTHER_W = 8
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic test_en_in,
   input wire logic [simt_pkg::DRIVE_W-1:0] drive_in,
   input wire logic func_shared_bus_request_in,
   input wire logic func_lowpower_ack_in,
   input wire logic func_clock_active_in,
   input wire logic [OTHER_W-1:0] func_other_in,
   input wire logic ebi_backoff_in,
   input wire logic ebi_grant_in,
   input wire logic lowpower_request_in,
   output logic shared_bus_request_out,
   output logic lowpower_ack_out,
   output logic clock_active_out,
   output logic [OTHER_W-1:0] other_out,
   output logic core_ebi_backoff_out,
   output logic core_ebi_grant_out,
   output logic core_lowpower_request_out
);
   import simt_pkg::*;

   // -------------------------------------------------------------------
   // External outputs
   // -------------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         shared_bus_request_out <= TIE_OUTPUT;
         lowpower_ack_out <= TIE_OUTPUT;
         clock_active_out <= TIE_OUTPUT;
         other_out <= '0;
      end
      else if (test_en_in)
      begin
         shared_bus_request_out <= drive_in[DRV_SHARED_BUS_REQ]; // [RULE1] [RULE10]
         lowpower_ack_out <= drive_in[DRV_LOWPOWER_ACK]; // [RULE11]
         clock_active_out <= drive_in[DRV_CLOCK_ACTIVE]; // [RULE12]
         other_out <= {OTHER_W{TIE_OUTPUT}}; // [RULE1]
      end
      else
      begin
         shared_bus_request_out <= func_shared_bus_request_in; // [RULE16]
         lowpower_ack_out <= func_lowpower_ack_in;
         clock_active_out <= func_clock_active_in;
         other_out <= func_other_in;
      end
   end

   // -------------------------------------------------------------------
   // Inputs toward functional logic
   // -------------------------------------------------------------------
   // Pins toggled by a test must not upset the functional logic
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         core_ebi_backoff_out <= TIE_CORE_BACKOFF;
         core_ebi_grant_out <= TIE_CORE_GRANT;
         core_lowpower_request_out <= TIE_CORE_LOWPOWER_REQ;
      end
      else if (test_en_in)
      begin
         core_ebi_backoff_out <= TIE_CORE_BACKOFF; // [RULE2]
         core_ebi_grant_out <= TIE_CORE_GRANT;
         core_lowpower_request_out <= TIE_CORE_LOWPOWER_REQ;
      end
      else
      begin
         core_ebi_backoff_out <= ebi_backoff_in; // [RULE16]
         core_ebi_grant_out <= ebi_grant_in;
         core_lowpower_request_out <= lowpower_request_in;
      end
   end

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   property p_test_drive;
      test_en_in |=> (shared_bus_request_out == $past(drive_in[DRV_SHARED_BUS_REQ]))
         && (lowpower_ack_out == $past(drive_in[DRV_LOWPOWER_ACK]))
         && (clock_active_out == $past(drive_in[DRV_CLOCK_ACTIVE]));
   endproperty
   a_test_drive: assert property (p_test_drive) // [RULE10]
      else $error("test mode outputs differ from drive register");

   property p_test_tie;
      test_en_in |=> (other_out == '0);
   endproperty
   a_test_tie: assert property (p_test_tie) // [RULE1]
      else $error("other outputs not tied off in test mode");

   property p_core_quiet;
      test_en_in ##1 test_en_in |-> !core_ebi_backoff_out && !core_ebi_grant_out
         && !core_lowpower_request_out;
   endproperty
   a_core_quiet: assert property (p_core_quiet) // [RULE2]
      else $error("pin changes reached functional logic in test mode");

   property p_functional;
      !test_en_in |=> (shared_bus_request_out == $past(func_shared_bus_request_in))
         && (other_out == $past(func_other_in))
         && (core_ebi_grant_out == $past(ebi_grant_in));
   endproperty
   a_functional: assert property (p_functional) // [RULE16]
      else $error("functional path not selected outside test mode");

endmodule

// file: dv/simt_apb_master.sv
// APB master model driving the integration test registers
`timescale 1ns/1ps
module simt_apb_master (
   input wire logic clk_in,
   output logic psel_out,
   output logic penable_out,
   output logic pwrite_out,
   output logic [simt_pkg::ADDR_W-1:0] paddr_out,
   output logic [simt_pkg::DATA_W-1:0] pwdata_out,
   input wire logic [simt_pkg::DATA_W-1:0] prdata_in,
   input wire logic pready_in,
   input wire logic pslverr_in
);
   import simt_pkg::*;
   initial
   begin
      psel_out = 1'h0;
      penable_out = 1'h0;
      pwrite_out = 1'h0;
      paddr_out = 13'h0000;
      pwdata_out = 32'h0000_0000;
   end
   // ----------
   // One transfer, answer taken on the ready edge
   // ----------
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr,
                       input logic [DATA_W-1:0] wdata,
                       output logic [DATA_W-1:0] rdata, output logic err);
      @(posedge clk_in);
      #1;
      psel_out = 1'h1;
      pwrite_out = wr;
      paddr_out = addr;
      pwdata_out = wdata;
      @(posedge clk_in);
      #1;
      penable_out = 1'h1;
      do
         @(posedge clk_in);
      while (pready_in !== 1'h1);
      rdata = prdata_in;
      err = pslverr_in;
      #1;
      psel_out = 1'h0;
      penable_out = 1'h0;
      // Released bus shows no stale values
      paddr_out = ~addr;
      pwdata_out = ~wdata;
   endtask
endmodule

// file: dv/static_mem_integration_test_regs_test.sv
// Self-checking bench for the static memory integration test registers
`timescale 1ns/1ps
module static_mem_integration_test_regs_test;
   import simt_pkg::*;
   typedef struct packed {
      logic t;
      logic [2:0] drv;
      logic [2:0] fn;
      logic [5:0] pins;
      logic [2:0] eo;
      logic [2:0] ec;
   } simt_row_t;
   localparam int N_ROWS = 5;
   localparam int MAX_CYCLES = 3000;
   localparam simt_row_t ROWS [N_ROWS] = '{
      '{1'h0, 3'h7, 3'h5, 6'h2A, 3'h5, 3'h4},
      '{1'h1, 3'h5, 3'h2, 6'h15, 3'h5, 3'h0},
      '{1'h1, 3'h2, 3'h7, 6'h3F, 3'h2, 3'h0},
      '{1'h0, 3'h0, 3'h2, 6'h15, 3'h2, 3'h3},
      '{1'h1, 3'h1, 3'h6, 6'h00, 3'h1, 3'h0}
   };
   logic clk_in = 1'h0;
   logic reset_in = 1'h1;
   logic ctrl_reset_state = 1'h0;
   logic [5:0] pins = 6'h00;
   logic [2:0] fn = 3'h0;
   logic [7:0] other = 8'h00;
   wire psel;
   wire penable;
   wire pwrite;
   wire [ADDR_W-1:0] paddr;
   wire [DATA_W-1:0] pwdata;
   wire [DATA_W-1:0] prdata;
   wire pready;
   wire pslverr;
   wire [2:0] outs;
   wire [2:0] core;
   wire [7:0] other_out;
   wire test_mode;
   logic [31:0] rd;
   logic err;
   simt_row_t r;
   int failures = 0;
   int n_checks = 0;
   int cycles = 0;

   always #5 clk_in = ~clk_in;

   simt_apb_master simt_apb_master_i (
      .clk_in(clk_in), .psel_out(psel), .penable_out(penable),
      .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
      .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr)
   );

   simt_regs simt_regs_i (
      .clk_in(clk_in), .reset_in(reset_in),
      .ctrl_reset_state_in(ctrl_reset_state),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr),
      .mem_clock_sync_tie_in(pins[5]), .ahb_clock_sync_tie_in(pins[4]),
      .ebi_backoff_in(pins[3]), .ebi_grant_in(pins[2]),
      .external_bus_share_tie_in(pins[1]), .lowpower_request_in(pins[0]),
      .func_shared_bus_request_in(fn[2]), .func_lowpower_ack_in(fn[1]),
      .func_clock_active_in(fn[0]), .func_other_in(other),
      .shared_bus_request_out(outs[2]), .lowpower_ack_out(outs[1]),
      .clock_active_out(outs[0]), .other_out(other_out),
      .core_ebi_backoff_out(core[2]), .core_ebi_grant_out(core[1]),
      .core_lowpower_request_out(core[0]), .test_mode_out(test_mode)
   );

   // ----------
   // Checking and closing
   // ----------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == MAX_CYCLES)
      begin
         failures++;
         end_of_test();
      end
   end

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      simt_apb_master_i.xfer(1'h1, a, d, rd, err);
   endtask

   task automatic rdr(input logic [ADDR_W-1:0] a);
      simt_apb_master_i.xfer(1'h0, a, 32'h0000_0000, rd, err);
   endtask

   // ----------
   // Main sequence
   // ----------
   initial
   begin
      repeat (6) @(posedge clk_in);
      #1;
      reset_in = 1'h0;
      check(32'(test_mode), 32'h0);
      check(32'(pready), 32'h1);
      rdr(OFF_TEST_CONFIG);
      check(rd, 32'h0);
      for (int i = 0; i < N_ROWS; i++)
      begin
         r = ROWS[i];
         wr(OFF_TEST_CONFIG, {31'h0, r.t});
         wr(OFF_OUTPUT_DRIVE, {29'h0, r.drv});
         fn = r.fn;
         pins = r.pins;
         other = {r.pins, 2'h3};
         @(posedge clk_in);
         @(posedge clk_in);
         #1;
         check(32'(outs), 32'(r.eo));
         check(32'(core), 32'(r.ec));
         check(32'(other_out), r.t ? 32'h0 : 32'({r.pins, 2'h3}));
         check(32'(test_mode), 32'(r.t));
         rdr(OFF_INPUT_VIEW);
         check(rd, {26'h0, r.pins});
         check(32'(err), 32'h0);
         rdr(OFF_TEST_CONFIG);
         check(rd, {31'h0, r.t});
         $display("row %0d done", i);
      end
      // Controller in Reset state
      ctrl_reset_state = 1'h1;
      wr(OFF_TEST_CONFIG, 32'h0);
      check(32'(err), 32'h1);
      rdr(OFF_TEST_CONFIG);
      check(32'(err), 32'h1);
      rdr(OFF_INPUT_VIEW);
      check(32'(err), 32'h1);
      rdr(OFF_OUTPUT_DRIVE);
      check(32'(err), 32'h1);
      wr(OFF_OUTPUT_DRIVE, 32'h0000_0004);
      check(32'(err), 32'h0);
      @(posedge clk_in);
      #1;
      check(32'(test_mode), 32'h1);
      check(32'(outs), 32'h4);
      ctrl_reset_state = 1'h0;
      $display("reset state test done");
      // Access kinds and unmapped place
      rdr(OFF_OUTPUT_DRIVE);
      check(rd, 32'h0);
      check(32'(err), 32'h0);
      wr(OFF_INPUT_VIEW, 32'h0000_003F);
      check(32'(err), 32'h1);
      rdr(13'h1E0C);
      check(rd, 32'h0);
      check(32'(err), 32'h1);
      $display("access kind test done");
      // Reset in mid-run with test mode on
      reset_in = 1'h1;
      @(posedge clk_in);
      #1;
      reset_in = 1'h0;
      check(32'(test_mode), 32'h0);
      rdr(OFF_TEST_CONFIG);
      check(rd, 32'h0);
      check(32'(outs), 32'(fn));
      $display("mid-run reset test done");
      end_of_test();
   end
endmodule
